//--- hw/csc_config_space.sv
// Configuration space with per-function resources and clock control.
// Assumes decoded single-cycle I/O strobes synchronous to ref_clk_in.
`timescale 1ns/1ps
`include "csc_params.svh"

module csc_config_space #(
  parameter int NF          = 6,
  parameter int GPIO_W      = 8,
  parameter int EXEMPT_PIN  = 6,
  parameter int WAKE_CYCLES = (`CSC_WAKE_US * `CSC_CLK_MHZ)
) (
  // Clock and reset
  input  wire logic                ref_clk_in,
  input  wire logic                rstn_in,
  // Straps
  input  wire logic                config_base_strap_in,
  input  wire logic [GPIO_W-1:0]   gpio_strap_in,
  // Host I/O cycles
  input  wire logic [15:0]         io_addr_in,
  input  wire logic                io_rd_in,
  input  wire logic                io_wr_in,
  input  wire logic [7:0]          io_wdata_in,
  output logic      [7:0]          io_rdata_out,
  output logic                     io_claim_out,
  // Function register access
  output logic      [NF-1:0]       func_hit_out,
  output logic      [4:0]          func_offset_out,
  output logic      [NF-1:0]       func_enable_out,
  // Pins and clock
  output logic      [GPIO_W-1:0]   gpio_mux_out,
  output logic      [GPIO_W-1:0]   gpio_pullup_out,
  output logic                     clk_enable_out,
  output logic                     mult_run_out
);

  // Range sizes in low address bits, bridge gives sixteen registers
  localparam logic [2:0] RBITS [6] = '{3'd3, 3'd3, 3'd3, 3'd3, 3'd1, 3'd4};
  // Legacy reset bases; zero for the vendor-specific functions
  localparam logic [15:0] DEF_BASE [6] =
    '{16'h03F0, 16'h0278, 16'h03F8, 16'h02F8, 16'h0000, 16'h0000};
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

  // Elaboration checks
  if (NF != 6) $error("csc_config_space serves exactly six functions");
  if (WAKE_CYCLES < 1) $error("WAKE_CYCLES must be at least one");
  if (EXEMPT_PIN >= GPIO_W) $error("EXEMPT_PIN outside the strap range");

  // Mask of the in-range low address bits
  function automatic logic [15:0] rmask(input int f);
    rmask = 16'((32'd1 << RBITS[f]) - 32'd1);
  endfunction

  // Alignment and range limits applied to a base value
  function automatic logic [15:0] base_fix(input int f,
                                           input logic [15:0] v);
    logic [15:0] t;
    t = v & ~rmask(f);
    if (f == csc_pkg::FN_FLOPPY || f == csc_pkg::FN_SERIAL1 ||
        f == csc_pkg::FN_SERIAL2)
      t = t & `CSC_LEGACY_HI_MASK;
    if (f == csc_pkg::FN_PARPORT && t > `CSC_PAR_LIMIT)
      t = `CSC_PAR_LIMIT;
    base_fix = t;
  endfunction

  // Register state
  logic [7:0]  idx_r;
  logic [7:0]  ldn_r;
  logic        lock_r;
  logic        sw_rst_r;
  logic        strap_done_r;
  logic        cfg_hi_r;
  logic        clk_en_r;
  logic        clk_en_d_r;
  logic        src_lock_r;
  logic [1:0]  src_r;
  logic [WAKE_W-1:0] wake_cnt_r;
  csc_pkg::csc_ck_state_t ck_state_r;
  csc_pkg::csc_ck_state_t ck_state_nxt;
  logic [7:0]  act_r   [NF];
  logic [15:0] base0_r [NF];
  logic [15:0] base1_r [NF];
  logic [7:0]  irqn_r  [NF];
  logic [7:0]  irqt_r  [NF];
  logic [7:0]  dma0_r  [NF];
  logic [7:0]  dma1_r  [NF];
  logic [7:0]  vend0_r [NF];
  logic [7:0]  vend1_r [NF];

  // Config port decode on all sixteen bits
  wire [15:0] cfg_base = cfg_hi_r ? `CSC_CFG_BASE_HI : `CSC_CFG_BASE_LO;
  wire        idx_hit  = (io_addr_in == cfg_base);
  wire        dat_hit  = (io_addr_in == cfg_base + 16'h0001);
  wire        io_req   = io_rd_in | io_wr_in;
  wire        dat_wr   = io_wr_in & dat_hit;
  wire        fsel_ok  = (ldn_r < 8'(NF));
  wire [2:0]  fsel     = ldn_r[2:0];
  wire        glob_wr  = dat_wr & (idx_r[7:4] != 4'h3) &
                         (idx_r[7:4] != 4'h6) & (idx_r[7:4] != 4'h7) &
                         (idx_r[7:4] != 4'hF);
  wire        fn_wr    = dat_wr & fsel_ok & ~glob_wr;
  wire        any_act;
  wire [NF-1:0] hit_vec;

  // Function range decode, active functions only
  genvar g;
  generate
    for (g = 0; g < NF; g++)
    begin : g_hit
      assign hit_vec[g] = act_r[g][`CSC_ACT_BIT] &
        ((io_addr_in & ~rmask(g)) == base0_r[g]);
    end
  endgenerate

  // Module enable status is any function active
  logic [NF-1:0] act_vec;
  always_comb
  begin
    for (int f = 0; f < NF; f++)
      act_vec[f] = act_r[f][`CSC_ACT_BIT];
  end
  assign any_act = |act_vec;

  // Clock control readback: source, enable, valid, module status
  wire [7:0] clk_rd = {3'h0, any_act, (ck_state_r == csc_pkg::CK_RUN),
                       clk_en_r, src_r};
  wire [7:0] fn_rd =
    (idx_r == `CSC_IDX_ACT)      ? act_r[fsel] :
    (idx_r == `CSC_IDX_BASE0_HI) ? base0_r[fsel][15:8] :
    (idx_r == `CSC_IDX_BASE0_LO) ? base0_r[fsel][7:0] :
    (idx_r == `CSC_IDX_BASE1_HI) ? base1_r[fsel][15:8] :
    (idx_r == `CSC_IDX_BASE1_LO) ? base1_r[fsel][7:0] :
    (idx_r == `CSC_IDX_IRQ_NUM)  ? irqn_r[fsel] :
    (idx_r == `CSC_IDX_IRQ_TYPE) ? irqt_r[fsel] :
    (idx_r == `CSC_IDX_DMA0)     ? dma0_r[fsel] :
    (idx_r == `CSC_IDX_DMA1)     ? dma1_r[fsel] :
    (idx_r == `CSC_IDX_VEND0)    ? vend0_r[fsel] :
    (idx_r == `CSC_IDX_VEND1)    ? vend1_r[fsel] : 8'h00;
  wire [7:0] glob_rd =
    (idx_r == `CSC_IDX_LDN)    ? ldn_r :
    (idx_r == `CSC_IDX_GCFG1)  ? {lock_r, 7'h00} :
    (idx_r == `CSC_IDX_CLKCTL) ? clk_rd : 8'h00;
  wire [7:0] dat_rd = glob_wr | (dat_hit & (idx_r[7:4] != 4'h3) &
                      (idx_r[7:4] != 4'h6) & (idx_r[7:4] != 4'h7) &
                      (idx_r[7:4] != 4'hF)) ? glob_rd :
                      (fsel_ok ? fn_rd : 8'h00);
  wire [4:0] offs_nxt = 5'(io_addr_in & 16'h001F);

  // Straps are caught one cycle after release, never under reset
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      strap_done_r    <= 1'b0;
      cfg_hi_r        <= 1'b0;
      gpio_mux_out    <= '0;
      gpio_pullup_out <= '0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r    <= 1'b1;
      cfg_hi_r        <= config_base_strap_in;
      gpio_mux_out    <= gpio_strap_in;
      gpio_pullup_out <= ~gpio_strap_in &
                         ~(GPIO_W'(1) << EXEMPT_PIN);
    end
  end

  // Host answers: claim only config port or active function range
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      io_rdata_out    <= 8'h00;
      io_claim_out    <= 1'b0;
      func_hit_out    <= '0;
      func_offset_out <= 5'h00;
    end
    else
    begin
      io_claim_out    <= io_req & strap_done_r &
                         (idx_hit | dat_hit | (|hit_vec));
      func_hit_out    <= io_req ? hit_vec : '0;
      func_offset_out <= offs_nxt;
      io_rdata_out    <= idx_hit ? idx_r : (dat_hit ? dat_rd : 8'h00);
    end
  end

  // Global registers; lock bit and source lock survive software reset
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      idx_r      <= 8'h00;
      ldn_r      <= 8'h00;
      lock_r     <= 1'b0;
      sw_rst_r   <= 1'b0;
      clk_en_r   <= 1'b0;
      clk_en_d_r <= 1'b0;
      src_r      <= csc_pkg::SRC_EXT48;
      src_lock_r <= 1'b0;
    end
    else
    begin
      clk_en_d_r <= clk_en_r;
      sw_rst_r   <= glob_wr & (idx_r == `CSC_IDX_GCFG1) &
                    io_wdata_in[`CSC_GCFG1_SWRST];
      if (io_wr_in & idx_hit)
        idx_r <= io_wdata_in;
      if (sw_rst_r)
      begin
        ldn_r    <= 8'h00;
        clk_en_r <= 1'b0;
      end
      else if (glob_wr)
      begin
        if (idx_r == `CSC_IDX_LDN)
          ldn_r <= io_wdata_in;
        if (idx_r == `CSC_IDX_GCFG1)
          lock_r <= lock_r | io_wdata_in[`CSC_GCFG1_LOCK];
        if (idx_r == `CSC_IDX_CLKCTL)
        begin
          clk_en_r <= io_wdata_in[`CSC_CLK_EN_BIT];
          if (!src_lock_r)
          begin
            src_r      <= io_wdata_in[1:0];
            src_lock_r <= 1'b1;
          end
        end
      end
    end
  end

  // Per-function registers, set back to their reset values by either reset
  generate
    for (g = 0; g < NF; g++)
    begin : g_fn
      wire wr_me = fn_wr & (fsel == 3'(g));
      always_ff @(posedge ref_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          act_r[g]   <= 8'h00;
          base0_r[g] <= DEF_BASE[g];
          base1_r[g] <= 16'h0000;
          irqn_r[g]  <= `CSC_IRQ_RST;
          irqt_r[g]  <= `CSC_IRQ_RST;
          dma0_r[g]  <= `CSC_DMA_NONE;
          dma1_r[g]  <= `CSC_DMA_NONE;
          vend0_r[g] <= `CSC_VEND_RST;
          vend1_r[g] <= `CSC_VEND_RST;
        end
        else if (sw_rst_r)
        begin
          act_r[g]   <= 8'h00;
          base0_r[g] <= DEF_BASE[g];
          base1_r[g] <= 16'h0000;
          irqn_r[g]  <= `CSC_IRQ_RST;
          irqt_r[g]  <= `CSC_IRQ_RST;
          dma0_r[g]  <= `CSC_DMA_NONE;
          dma1_r[g]  <= `CSC_DMA_NONE;
          vend0_r[g] <= `CSC_VEND_RST;
          vend1_r[g] <= `CSC_VEND_RST;
        end
        else if (wr_me)
        begin
          case (idx_r)
            `CSC_IDX_ACT:      act_r[g] <= {7'h00, io_wdata_in[0]};
            `CSC_IDX_BASE0_HI: base0_r[g] <=
              base_fix(g, {io_wdata_in, base0_r[g][7:0]});
            `CSC_IDX_BASE0_LO: base0_r[g] <=
              base_fix(g, {base0_r[g][15:8], io_wdata_in});
            `CSC_IDX_BASE1_HI: base1_r[g] <=
              base_fix(g, {io_wdata_in, base1_r[g][7:0]});
            `CSC_IDX_BASE1_LO: base1_r[g] <=
              base_fix(g, {base1_r[g][15:8], io_wdata_in});
            `CSC_IDX_IRQ_NUM:  irqn_r[g] <= io_wdata_in;
            `CSC_IDX_IRQ_TYPE: irqt_r[g] <= {6'h00, io_wdata_in[1:0]};
            `CSC_IDX_DMA0:     dma0_r[g] <= {5'h00, io_wdata_in[2:0]};
            `CSC_IDX_DMA1:     dma1_r[g] <= {5'h00, io_wdata_in[2:0]};
            `CSC_IDX_VEND0:    vend0_r[g] <= io_wdata_in;
            `CSC_IDX_VEND1:    vend1_r[g] <= io_wdata_in;
            default:           act_r[g] <= act_r[g];
          endcase
        end
      end
    end
  endgenerate

  // Function enables; bridge runs while its registers stay closed
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      func_enable_out <= '0;
    else
      func_enable_out <= act_vec |
        (NF'(1) << csc_pkg::FN_BRIDGE);
  end

  // Multiplier sequencing; external source is valid at once
  always_comb
  begin
    ck_state_nxt = ck_state_r;
    case (ck_state_r)
      csc_pkg::CK_OFF:
        if (clk_en_r & ~clk_en_d_r)
          ck_state_nxt = (src_r == csc_pkg::SRC_EXT48) ?
                         csc_pkg::CK_RUN : csc_pkg::CK_WAIT;
      csc_pkg::CK_WAIT:
        if (!clk_en_r)
          ck_state_nxt = csc_pkg::CK_OFF;
        else if (wake_cnt_r == WAKE_W'(WAKE_CYCLES - 1))
          ck_state_nxt = csc_pkg::CK_RUN;
      csc_pkg::CK_RUN:
        if (!clk_en_r)
          ck_state_nxt = csc_pkg::CK_OFF;
      default:
        ck_state_nxt = csc_pkg::CK_OFF;
    endcase
  end

  // Wake counter only runs while waiting, so restarts begin at zero
  always_ff @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ck_state_r     <= csc_pkg::CK_OFF;
      wake_cnt_r     <= '0;
      clk_enable_out <= 1'b0;
      mult_run_out   <= 1'b0;
    end
    else
    begin
      ck_state_r     <= ck_state_nxt;
      wake_cnt_r     <= (ck_state_r == csc_pkg::CK_WAIT) ?
                        wake_cnt_r + WAKE_W'(1) : '0;
      clk_enable_out <= (ck_state_nxt == csc_pkg::CK_RUN);
      mult_run_out   <= (ck_state_nxt != csc_pkg::CK_OFF) &
                        (src_r != csc_pkg::SRC_EXT48);
    end
  end

  // Checks
  a_claim_active: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    func_hit_out != '0 |-> (func_hit_out & ~$past(act_vec)) == '0)
    else $error("claimed range of an inactive function");
  a_sw_reset_clr: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    sw_rst_r |=> (act_vec == '0) && !clk_en_r && $stable(lock_r))
    else $error("software reset left state behind");
  a_clk_held: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    ck_state_r == csc_pkg::CK_WAIT |-> !clk_enable_out && !clk_rd[3])
    else $error("clock released before stable");
  a_src_frozen: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    src_lock_r |=> $stable(src_r))
    else $error("source changed after lock");
  a_base_align: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (base0_r[csc_pkg::FN_BRIDGE] & 16'h000F) == 16'h0000)
    else $error("bridge base not aligned");
  a_base_limit: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    base0_r[csc_pkg::FN_PARPORT] <= `CSC_PAR_LIMIT &&
    base0_r[csc_pkg::FN_SERIAL1][15:11] == 5'h00)
    else $error("base beyond its range");
  a_ext_valid: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    clk_en_r && !clk_en_d_r && src_r == csc_pkg::SRC_EXT48 |=>
    clk_enable_out ##1 clk_rd[3])
    else $error("external clock not valid at once");
  a_clk_stop: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    !clk_en_r |=> !clk_enable_out)
    else $error("clock kept after enable cleared");

endmodule // csc_config_space

//--- hw/csc_params.svh
// Offsets, field positions, reset values and timing figures of the
// configuration space and clock control block.
// Assumes inclusion by bare name from the design files.
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// Configuration port bases selected by the strap
`define CSC_CFG_BASE_LO     16'h002E
`define CSC_CFG_BASE_HI     16'h004E
// Global register indexes
`define CSC_IDX_LDN         8'h07
`define CSC_IDX_GCFG1       8'h21
`define CSC_IDX_CLKCTL      8'h29
// Per-function register indexes
`define CSC_IDX_ACT         8'h30
`define CSC_IDX_BASE0_HI    8'h60
`define CSC_IDX_BASE0_LO    8'h61
`define CSC_IDX_BASE1_HI    8'h62
`define CSC_IDX_BASE1_LO    8'h63
`define CSC_IDX_IRQ_NUM     8'h70
`define CSC_IDX_IRQ_TYPE    8'h71
`define CSC_IDX_DMA0        8'h74
`define CSC_IDX_DMA1        8'h75
`define CSC_IDX_VEND0       8'hF0
`define CSC_IDX_VEND1       8'hF1
// Field positions
`define CSC_ACT_BIT         0
`define CSC_GCFG1_SWRST     1
`define CSC_GCFG1_LOCK      7
`define CSC_CLK_EN_BIT      2
`define CSC_CLK_VALID_BIT   3
`define CSC_CLK_MODEN_BIT   4
// Reset values
`define CSC_DMA_NONE        8'h04
`define CSC_IRQ_RST         8'h00
`define CSC_VEND_RST        8'h00
// Address range limits
`define CSC_PAR_LIMIT       16'h03F8
`define CSC_LEGACY_HI_MASK  16'h07FF
// Multiplier wake-up time, microseconds, and clock rate, MHz
`define CSC_WAKE_US         33000
`define CSC_CLK_MHZ         50

`endif

//--- hw/csc_pkg.sv
// Types shared by the configuration space and clock control block.
// Assumes nothing of its surroundings.
package csc_pkg;

  // Logical functions, also the logical device number
  typedef enum logic [2:0] {
    FN_FLOPPY = 3'b000,
    FN_PARPORT = 3'b001,
    FN_SERIAL1 = 3'b010,
    FN_SERIAL2 = 3'b011,
    FN_JOYSTICK = 3'b100,
    FN_BRIDGE = 3'b101
  } csc_func_t;

  // Clock source select encoding
  typedef enum logic [1:0] {
    SRC_EXT48 = 2'b00,
    SRC_MUL32K = 2'b01,
    SRC_MUL14M = 2'b10,
    SRC_RSVD = 2'b11
  } csc_src_t;

  // Multiplier states
  typedef enum logic [1:0] {
    CK_OFF = 2'b00,
    CK_WAIT = 2'b01,
    CK_RUN = 2'b10
  } csc_ck_state_t;

endpackage

//--- testbench/csc_host_model.sv
// Host-side model issuing I/O cycles to the configuration space.
// Assumes the block answers one edge after each one-cycle strobe.
`timescale 1ns/1ps

module csc_host_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Cycle outputs
  output logic      [15:0] io_addr_out,
  output logic             io_rd_out,
  output logic             io_wr_out,
  output logic      [7:0]  io_wdata_out,
  // Answers
  input  wire logic [7:0]  io_rdata_in,
  input  wire logic        io_claim_in
);
  logic [15:0] cfg_base;

  // Idle bus at time zero
  initial
  begin
    io_addr_out = 16'hFFFF;
    io_rd_out = 1'b0;
    io_wr_out = 1'b0;
    io_wdata_out = 8'h00;
    cfg_base = 16'h002E;
  end

  // One strobe; answer taken right after the edge that took it
  task automatic cycle(input logic wr, input logic [15:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic c);
    @(posedge ref_clk_in);
    #1;
    io_addr_out = a;
    io_wdata_out = d;
    io_rd_out = ~wr;
    io_wr_out = wr;
    @(posedge ref_clk_in);
    #1;
    io_rd_out = 1'b0;
    io_wr_out = 1'b0;
    io_addr_out = ~a; // Released lines never keep the old value
    io_wdata_out = ~d;
    q = io_rdata_in;
    c = io_claim_in;
  endtask

  // Index then data, as the port pair demands
  task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic c;
    cycle(1'b1, cfg_base, i, q, c);
    cycle(1'b1, cfg_base + 16'h0001, d, q, c);
  endtask

  task automatic cfg_rd(input logic [7:0] i, output logic [7:0] q);
    logic c;
    cycle(1'b1, cfg_base, i, q, c);
    cycle(1'b0, cfg_base + 16'h0001, 8'h00, q, c);
  endtask

  // Source and enable go in one write, then valid is polled
  task automatic clk_on(input logic [1:0] s, output int n);
    logic [7:0] q;
    cfg_wr(8'h29, {5'h00, 1'b1, s});
    n = 0;
    q = 8'h00;
    while (q[3] !== 1'b1 && n < 50)
    begin
      cfg_rd(8'h29, q);
      n++;
    end
  endtask

  // Clocked functions only come up once the clock is valid
  task automatic activate(input logic [2:0] f, input logic on);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'h00;
    while (on && f < 3'd4 && q[3] !== 1'b1 && n < 50)
    begin
      cfg_rd(8'h29, q);
      n++;
    end
    cfg_wr(8'h07, {5'h00, f});
    cfg_wr(8'h30, {7'h00, on});
  endtask

  // Clock is only stopped once no module is enabled
  task automatic clk_off(input logic [1:0] s);
    logic [7:0] q;
    int n;
    n = 0;
    q = 8'hFF;
    while (q[4] !== 1'b0 && n < 50)
    begin
      cfg_rd(8'h29, q);
      n++;
    end
    cfg_wr(8'h29, {5'h00, 1'b0, s});
  endtask
endmodule // csc_host_model

//--- testbench/tb.sv
// Self-checking bench for the configuration space and clock control.
// Assumes the host model in csc_host_model.sv drives the I/O cycles.
`timescale 1ns/1ps

module tb;
  logic        ref_clk_in, rstn_in, strap, c;
  logic [7:0]  gstrap, q, h;
  logic [15:0] addr, v, b, sz;
  logic        io_rd, io_wr, claim;
  logic [7:0]  wdata, rdata, mux, pull;
  logic [5:0]  hit, fen;
  logic [4:0]  offs;
  logic        clk_en, mrun;
  int          error_cnt, compares, n, off;
  logic [7:0]  idx [7] = '{8'h62, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0};
  // Second base high byte kept at 03 so the parallel clamp never bites
  logic [7:0]  msk [7] = '{8'h03, 8'hF0, 8'h0F, 8'h03, 8'h03, 8'h03, 8'hFF};

  csc_config_space #(.WAKE_CYCLES(10)) dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .config_base_strap_in(strap), .gpio_strap_in(gstrap),
    .io_addr_in(addr), .io_rd_in(io_rd), .io_wr_in(io_wr),
    .io_wdata_in(wdata), .io_rdata_out(rdata), .io_claim_out(claim),
    .func_hit_out(hit), .func_offset_out(offs), .func_enable_out(fen),
    .gpio_mux_out(mux), .gpio_pullup_out(pull),
    .clk_enable_out(clk_en), .mult_run_out(mrun));

  csc_host_model host (
    .ref_clk_in(ref_clk_in), .io_addr_out(addr), .io_rd_out(io_rd),
    .io_wr_out(io_wr), .io_wdata_out(wdata), .io_rdata_in(rdata),
    .io_claim_in(claim));

  // 50 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  function automatic int rbits(input int f);
    return (f == 4) ? 1 : (f == 5) ? 4 : 3;
  endfunction

  function automatic logic [15:0] legacy(input int f);
    logic [15:0] t [6] = '{16'h03F0, 16'h0278, 16'h03F8, 16'h02F8, 16'h0, 16'h0};
    return t[f];
  endfunction

  // Legacy high bits cleared, parallel clamped, low range bits zero
  function automatic logic [15:0] exp_base(input int f, input logic [15:0] x);
    logic [15:0] r;
    r = x;
    if (f == 0 || f == 2 || f == 3) r = r & 16'h07FF;
    if (f == 1 && r > 16'h03F8) r = 16'h03F8;
    return r & ~((16'h0001 << rbits(f)) - 16'h0001);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_base(output logic [15:0] r);
    logic [7:0] hi, lo;
    host.cfg_rd(8'h60, hi);
    host.cfg_rd(8'h61, lo);
    r = {hi, lo};
  endtask

  // Hardware reset held 12 cycles with fresh random straps
  task automatic hw_reset();
    @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b0;
    strap = 1'($urandom);
    gstrap = 8'($urandom);
    repeat (12) @(posedge ref_clk_in);
    #1;
    rstn_in = 1'b1;
    host.cfg_base = strap ? 16'h004E : 16'h002E;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog near ten times the expected few thousand cycles
  initial
  begin
    #400000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    rstn_in = 1'b0;
    strap = 1'b0;
    gstrap = 8'h00;
    error_cnt = 0;
    compares = 0;
    void'($urandom(32'h16C796EB));
    // Each source after its own hardware reset
    for (int s = 0; s < 3; s++)
    begin
      hw_reset();
      chk(mux, gstrap);
      chk(pull, ~gstrap & 8'hBF);
      chk(fen, 6'h20);
      chk(clk_en, 1'b0);
      host.cycle(1'b0, strap ? 16'h002F : 16'h004F, 8'h00, q, c);
      chk(c, 1'b0);
      host.cycle(1'b0, host.cfg_base ^ 16'h8001, 8'h00, q, c);
      chk(c, 1'b0);
      host.clk_on(2'(s), n);
      chk(clk_en, 1'b1);
      chk(mrun, s != 0);
      chk(n == 1, s == 0);
      host.cfg_wr(8'h29, {5'h00, 1'b1, 2'((s + 1) % 3)});
      host.cfg_rd(8'h29, q);
      chk(q[3:0], {2'b11, 2'(s)});
      for (int f = 0; f < 6; f++)
      begin
        host.cfg_wr(8'h07, 8'(f));
        host.cfg_rd(8'h30, q);
        chk(q, 8'h00);
        rd_base(b);
        chk(b, legacy(f));
        host.cfg_rd(8'h74, q);
        chk(q, 8'h04);
        v = (f == 1) ? 16'($urandom % 32'h3F9) : 16'($urandom);
        host.cfg_wr(8'h60, v[15:8]);
        host.cfg_wr(8'h61, v[7:0]);
        rd_base(b);
        chk(b, exp_base(f, v));
        sz = 16'h0001 << rbits(f);
        off = $urandom % sz;
        if ((b + 16'(off)) >> 1 != host.cfg_base >> 1)
        begin
          host.cycle(1'b0, b + 16'(off), 8'h00, q, c);
          chk(c, 1'b0);
          host.activate(3'(f), 1'b1);
          @(posedge ref_clk_in);
          #1;
          chk(fen[f], 1'b1);
          host.cycle(1'b0, b + 16'(off), 8'h00, q, c);
          chk({c, hit}, {1'b1, 6'h01 << f});
          chk(offs, 5'(b + 16'(off)));
          if ((b + sz) >> 1 != host.cfg_base >> 1)
          begin
            host.cycle(1'b1, b + sz, 8'h5A, q, c);
            chk(c, 1'b0);
          end
        end
        for (int k = 0; k < 7; k++)
        begin
          h = 8'($urandom) & msk[k];
          host.cfg_wr(idx[k], h);
          host.cfg_rd(idx[k], q);
          chk(q, h);
        end
        host.activate(3'(f), 1'b0);
        @(posedge ref_clk_in);
        #1;
        chk(fen[f], f == 5);
      end
      host.clk_off(2'(s));
      @(posedge ref_clk_in);
      #1;
      chk({clk_en, mrun}, 2'b00);
    end
    // Software reset keeps the lock bit, restores defaults
    host.clk_on(2'b01, n);
    host.activate(3'd1, 1'b1);
    host.cfg_wr(8'h61, 8'hFF);
    host.cfg_wr(8'h60, 8'hFF);
    rd_base(b);
    chk(b, 16'h03F8);
    host.cfg_wr(8'h21, 8'h80);
    host.cfg_wr(8'h21, 8'h82);
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(fen, 6'h20);
    chk(clk_en, 1'b0);
    host.cfg_rd(8'h21, q);
    chk(q[7], 1'b1);
    host.cfg_wr(8'h07, 8'h01);
    rd_base(b);
    chk(b, 16'h0278);
    host.cfg_rd(8'h29, q);
    chk(q, 8'h02);
    hw_reset();
    host.cfg_rd(8'h21, q);
    chk(q[7], 1'b0);
    host.cfg_rd(8'h29, q);
    chk(q, 8'h00);
    print_verdict();
  end
endmodule // tb
